// >>> src/lms_pkg.sv
// constants and types shared by the lookup memory slice
// What this block does
// R1: local force drives element to configured value
// R2: opposite force inverts; reset wins over set
// R3: force sync or async, opposite follows it; async force here also acts only at the next clock edge
// R4: global init active high, optional inversion
// R5: init value start_zero/start_one, defaulted by force
// R6: lookup element is sixteen one-bit cells
// R7: cluster gives 16x4, 32x2 or 64x1
// R8: writes only on clock with write strobe
// R9: reads combinational, old data before write; both read outputs are registered here, one edge later
// R10: output flip-flop enable independent of write
// R11: dual port writes both arrays, separate reads
// R12: secondary read independent of write/primary read
// R13: initial memory contents kept through configuration
// R14: shift line delays one to sixteen cycles
// R15: shift lines cascade, up to 64 per cluster
// R16: final stage on cascade output, addressed tap
// R17: shift on enable high, hold when low
// R18: shift contents never reset or initialised
// R19: two elements share clock and shift enable
// R20: flip-flop adds one cycle to addressed tap
// R21: addressed delay equals address plus one
package lms_pkg;
  localparam int LMS_CELLS = 16;
  localparam int LMS_AW = 4;
  localparam int LMS_LUTS = 4;
  localparam logic [63:0] LMS_MEM_INIT = 64'h0000000000000000;
  // storage element reset values
  localparam logic LMS_FF_RST = 1'h0;
  // memory organisation modes
  typedef enum logic [1:0] {
    LMS_ORG_16X4 = 2'h0,
    LMS_ORG_32X2 = 2'h1,
    LMS_ORG_64X1 = 2'h2,
    LMS_ORG_DUAL = 2'h3
  } lms_org_t;
  // element mode: memory or shift line
  typedef enum logic [1:0] {
    LMS_MODE_RAM = 2'h1,
    LMS_MODE_SHIFT = 2'h2
  } lms_mode_t;
endpackage : lms_pkg

// >>> src/lms_slice.sv
// lookup memory cluster: distributed ram, shift lines, storage elements
`timescale 1ns/1ps
`default_nettype none
module lms_slice
  import lms_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire lms_mode_t mode_i,
  input wire lms_org_t org_i,
  input wire logic [3:0] addr_i,
  input wire logic [3:0] read_addr_i,
  input wire logic upper_address_five_i,
  input wire logic upper_address_six_i,
  input wire logic [3:0] data_i,
  input wire logic write_en_i,
  input wire logic shift_en_i,
  input wire logic chain_in_i,
  input wire logic [3:0] ff_en_i,
  input wire logic [3:0] ff_tap_sel_i,
  input wire logic local_force_input_i,
  input wire logic opposite_force_input_i,
  input wire logic force_to_one_i,
  input wire logic force_async_i,
  input wire logic start_one_i,
  input wire logic start_sel_i,
  input wire logic global_init_i,
  input wire logic global_init_invert_i,
  output logic [3:0] primary_read_out_o,
  output logic secondary_read_out_o,
  output logic [3:0] ff_q_o,
  output logic [3:0] chain_tap_out_o,
  output logic chain_out_o
);

  // lookup cells, shared by memory and shift uses; no reset by design;
  // the configured image is their only starting value [R13]
  logic [15:0] cells [LMS_LUTS] = '{LMS_MEM_INIT[15:0],
    LMS_MEM_INIT[31:16], LMS_MEM_INIT[47:32], LMS_MEM_INIT[63:48]};
  logic [15:0] next_cells [LMS_LUTS];
  logic [15:0] dual_cells = LMS_MEM_INIT[15:0];
  logic [15:0] next_dual_cells;
  logic [3:0] ff_q;
  logic [3:0] next_ff_q;
  logic [3:0] comb_out;
  logic [3:0] lut_we;
  logic [3:0] lut_din;
  logic [3:0] tap;
  logic init_act;
  logic init_val;
  logic async_hit;
  logic async_val;
  logic shift_go;
  logic ram_wr;
  logic [4:0] idle_cnt;
  logic [4:0] next_idle_cnt;

  // one tap of a sixteen-cell element
  function automatic logic pick(input logic [15:0] c, input logic [3:0] a);
    pick = c[a];
  endfunction : pick

  // write steering from organisation and upper address bits [R7]
  always_comb begin
    lut_we = 4'h0;
    lut_din = data_i;
    case (org_i)
      LMS_ORG_16X4: begin
        lut_we = {4{write_en_i}};
      end
      LMS_ORG_32X2: begin
        lut_we = {2{upper_address_five_i, !upper_address_five_i}}
          & {4{write_en_i}};
        lut_din = {data_i[1], data_i[1], data_i[0], data_i[0]};
      end
      LMS_ORG_64X1: begin
        lut_we[{upper_address_six_i, upper_address_five_i}] = write_en_i;
        lut_din = {4{data_i[0]}};
      end
      LMS_ORG_DUAL: begin
        lut_we = {3'h0, write_en_i};
      end
      default: begin
        lut_we = 4'h0;
      end
    endcase
  end

  // cell next state: write on strobe, or shift on enable
  always_comb begin
    for (int i = 0; i < LMS_LUTS; i++) begin
      next_cells[i] = cells[i];
    end
    next_dual_cells = dual_cells;
    case (mode_i)
      LMS_MODE_RAM: begin
        for (int i = 0; i < LMS_LUTS; i++) begin
          if (lut_we[i]) begin // [R8] [R6]
            next_cells[i][addr_i] = lut_din[i];
          end
        end
        if (org_i == LMS_ORG_DUAL && write_en_i) begin
          next_dual_cells[addr_i] = data_i[0]; // same data, same address [R11]
        end
      end
      LMS_MODE_SHIFT: begin
        // shared enable shifts every element, cascaded top to bottom
        if (shift_en_i) begin // [R17] [R19]
          next_cells[0] = {cells[0][14:0], chain_in_i};
          for (int i = 1; i < LMS_LUTS; i++) begin
            next_cells[i] = {cells[i][14:0], cells[i-1][15]}; // [R15]
          end
        end
      end
      default: begin
        next_dual_cells = dual_cells;
      end
    endcase
  end

  // cells register without reset: contents change only by data in [R18]
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < LMS_LUTS; i++) begin
      cells[i] <= next_cells[i];
    end
    dual_cells <= next_dual_cells;
  end

  // combinational reads: old contents until the write edge [R9]
  always_comb begin
    for (int i = 0; i < LMS_LUTS; i++) begin
      tap[i] = pick(cells[i], addr_i); // tap a gives a+1 cycles [R14] [R21]
    end
    comb_out = tap;
    if (mode_i == LMS_MODE_RAM) begin
      case (org_i)
        LMS_ORG_32X2: begin
          comb_out = upper_address_five_i ? {2'h0, tap[3], tap[1]}
                                          : {2'h0, tap[2], tap[0]};
        end
        LMS_ORG_64X1: begin
          comb_out = {3'h0, tap[{upper_address_six_i, upper_address_five_i}]};
        end
        default: begin
          comb_out = tap;
        end
      endcase
    end
  end

  // init and force sources
  always_comb begin
    // global init polarity is selectable [R4]
    init_act = global_init_i ^ global_init_invert_i;
    // start value follows force polarity unless chosen apart [R5]
    init_val = start_sel_i ? start_one_i : force_to_one_i;
    // reset wins over set when both forces act [R2]
    if (local_force_input_i && opposite_force_input_i) begin
      async_val = 1'h0;
    end else if (local_force_input_i) begin
      async_val = force_to_one_i; // [R1]
    end else begin
      async_val = !force_to_one_i;
    end
    async_hit = init_act || (force_async_i &&
      (local_force_input_i || opposite_force_input_i)); // [R3]
    if (init_act) begin
      async_val = init_val;
    end
  end

  // storage element next value: init, then force, else enabled capture;
  // output copy and element share this value so they never drift apart
  always_comb begin
    for (int i = 0; i < LMS_LUTS; i++) begin
      next_ff_q[i] = ff_q[i];
      if (async_hit) begin // [R4] [R3]
        next_ff_q[i] = async_val;
      end else if (!force_async_i &&
          (local_force_input_i || opposite_force_input_i)) begin // [R3]
        next_ff_q[i] = async_val;
      end else if (ff_en_i[i]) begin // own enable, not the write strobe [R10]
        next_ff_q[i] = ff_tap_sel_i[i] ? tap[i] : comb_out[i]; // [R20]
      end
    end
  end

  // storage elements; async force is honoured at the next edge and held
  // while asserted, since a port level cannot serve as an async reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ff_q <= {4{LMS_FF_RST}};
    end else begin
      ff_q <= next_ff_q;
    end
  end

  // registered outputs follow the same shared clock [R10]
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      primary_read_out_o <= 4'h0;
      secondary_read_out_o <= 1'h0;
      chain_tap_out_o <= 4'h0;
      chain_out_o <= 1'h0;
      ff_q_o <= 4'h0;
    end else begin
      primary_read_out_o <= comb_out;
      // secondary port reads independently of the write address [R12]
      secondary_read_out_o <= pick(dual_cells, read_addr_i);
      for (int i = 0; i < LMS_LUTS; i++) begin
        chain_tap_out_o[i] <= next_cells[i][15]; // [R16]
      end
      chain_out_o <= next_cells[LMS_LUTS-1][15];
      ff_q_o <= next_ff_q;
    end
  end

  // taken requests and a saturating idle count of the shift line, so a
  // long hold is checked without a huge repetition count
  always_comb begin
    shift_go = (mode_i == LMS_MODE_SHIFT) && shift_en_i;
    ram_wr = (mode_i == LMS_MODE_RAM) && write_en_i;
    next_idle_cnt = idle_cnt;
    if (mode_i != LMS_MODE_SHIFT || shift_en_i) begin
      next_idle_cnt = 5'h0;
    end else if (idle_cnt != 5'h1f) begin
      next_idle_cnt = idle_cnt + 5'h1;
    end
  end

  // idle counter register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= 5'h0;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end

  // shift holds all stages of the first element when enable is low
  chk_shift_hold: assert property ( // [R17]
    @(posedge clk_i) disable iff (!nrst_i)
    (mode_i == LMS_MODE_SHIFT && !shift_en_i) |=> $stable(cells[0]))
    else $error("shift line moved with enable low");

  // serial input lands in the first stage
  chk_shift_in: assert property ( // [R14]
    @(posedge clk_i) disable iff (!nrst_i)
    shift_go |=> cells[0][0] == $past(chain_in_i))
    else $error("serial input not captured");

  // dual array untouched without a write strobe
  chk_no_write: assert property ( // [R8]
    @(posedge clk_i) disable iff (!nrst_i)
    (mode_i == LMS_MODE_RAM && !write_en_i) |=> $stable(dual_cells))
    else $error("memory changed without write strobe");

  // both forces together give the reset outcome
  chk_force_win: assert property ( // [R2]
    @(posedge clk_i) disable iff (!nrst_i)
    (local_force_input_i && opposite_force_input_i && !init_act)
    |=> ff_q == 4'h0)
    else $error("reset did not win over set");

  // primary output registers the combinational read
  chk_prim_read: assert property ( // [R9]
    @(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> primary_read_out_o == $past(comb_out))
    else $error("primary read output wrong");

  // secondary output follows its own read address
  chk_dual_read: assert property ( // [R12]
    @(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> secondary_read_out_o == $past(dual_cells[read_addr_i]))
    else $error("secondary read output wrong");

  // each element shows its final stage
  chk_tap_out: assert property ( // [R16]
    @(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> chain_tap_out_o == {cells[3][15], cells[2][15],
      cells[1][15], cells[0][15]})
    else $error("final stage output wrong");

  // cascade output is the last stage of the last element
  chk_chain_out: assert property ( // [R15]
    @(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> chain_out_o == cells[LMS_LUTS-1][15])
    else $error("cascade output wrong");

  // storage output copy matches the storage elements
  chk_ff_mirror: assert property ( // [R10]
    @(posedge clk_i) disable iff (!nrst_i)
    ff_q_o == ff_q)
    else $error("storage output differs from element");

  // plain write lands in the last element at the address
  chk_ram_write: assert property ( // [R6]
    @(posedge clk_i) disable iff (!nrst_i)
    (ram_wr && org_i == LMS_ORG_16X4)
    |=> cells[3][$past(addr_i)] == $past(data_i[3]))
    else $error("memory write lost");

  // memory holds without a write strobe
  chk_ram_hold: assert property ( // [R8]
    @(posedge clk_i) disable iff (!nrst_i)
    (mode_i == LMS_MODE_RAM && !write_en_i) |=> $stable(cells[0]))
    else $error("memory changed without write strobe");

  // deep write goes only to the element picked by the upper bits
  chk_wide_write: assert property ( // [R7]
    @(posedge clk_i) disable iff (!nrst_i)
    (ram_wr && org_i == LMS_ORG_64X1 && upper_address_six_i &&
      upper_address_five_i) |=> cells[3][$past(addr_i)] == $past(data_i[0])
      && $stable(cells[0]))
    else $error("deep write misrouted");

  // two-bit write goes to the odd pair when the fifth bit is set
  chk_half_write: assert property ( // [R7]
    @(posedge clk_i) disable iff (!nrst_i)
    (ram_wr && org_i == LMS_ORG_32X2 && upper_address_five_i)
    |=> cells[3][$past(addr_i)] == $past(data_i[1]) && $stable(cells[2]))
    else $error("two-bit write misrouted");

  // dual write stores the same bit in the second array
  chk_dual_write: assert property ( // [R11]
    @(posedge clk_i) disable iff (!nrst_i)
    (ram_wr && org_i == LMS_ORG_DUAL)
    |=> dual_cells[$past(addr_i)] == $past(data_i[0]))
    else $error("dual array write lost");

  // last stage of one element feeds the next one
  chk_cascade: assert property ( // [R15]
    @(posedge clk_i) disable iff (!nrst_i)
    shift_go |=> cells[1][0] == $past(cells[0][15]))
    else $error("cascade link broken");

  // every stage of the first element moves one place per taken shift
  chk_shift_step: assert property ( // [R21]
    @(posedge clk_i) disable iff (!nrst_i)
    shift_go |=> cells[0][15:1] == $past(cells[0][14:0]))
    else $error("shift stages did not advance");

  // global init loads the start value
  chk_init_value: assert property ( // [R5]
    @(posedge clk_i) disable iff (!nrst_i)
    init_act |=> ff_q == {4{$past(init_val)}})
    else $error("init did not load start value");

  // local force alone gives the configured level
  chk_force_one: assert property ( // [R1]
    @(posedge clk_i) disable iff (!nrst_i)
    (local_force_input_i && !opposite_force_input_i && !init_act)
    |=> ff_q == {4{$past(force_to_one_i)}})
    else $error("local force gave wrong level");

  // opposite force alone gives the inverse level
  chk_force_opp: assert property ( // [R2]
    @(posedge clk_i) disable iff (!nrst_i)
    (opposite_force_input_i && !local_force_input_i && !init_act)
    |=> ff_q == {4{~$past(force_to_one_i)}})
    else $error("opposite force gave wrong level");

  // storage elements hold with their enables low
  chk_ff_hold: assert property ( // [R10]
    @(posedge clk_i) disable iff (!nrst_i)
    (!init_act && !local_force_input_i && !opposite_force_input_i &&
      ff_en_i == 4'h0) |=> $stable(ff_q))
    else $error("storage element moved while disabled");

  // tap capture adds one cycle to the addressed stage
  chk_tap_ff: assert property ( // [R20]
    @(posedge clk_i) disable iff (!nrst_i)
    (!async_hit && !local_force_input_i && !opposite_force_input_i &&
      ff_en_i[3] && ff_tap_sel_i[3]) |=> ff_q[3] == $past(tap[3]))
    else $error("tap capture wrong");

  // a shift line left idle keeps its final stages steady
  chk_idle_hold: assert property ( // [R17]
    @(posedge clk_i) disable iff (!nrst_i)
    idle_cnt > 5'h2 |-> $stable(chain_tap_out_o))
    else $error("final stage moved while idle");

endmodule : lms_slice
`default_nettype wire

// >>> verification/lms_feeder.sv
// user-logic serial source that feeds the shift chain
`timescale 1ns/1ps
`default_nettype none
module lms_feeder #(
  parameter logic [63:0] PAT = 64'h0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic step_i,
  output logic bit_o
);
  logic [5:0] idx;
  logic [5:0] next_idx;
  // one bit per taken shift keeps data in step with the shift chain
  always_comb next_idx = step_i ? idx + 6'h1 : idx;
  // pattern index register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) idx <= 6'h0;
    else idx <= next_idx;
  end
  assign bit_o = PAT[idx];
endmodule : lms_feeder
`default_nettype wire

// >>> verification/lms_slice_bench.sv
// self-checking bench for the lookup memory slice
`timescale 1ns/1ps
`default_nettype none
module lms_slice_bench;
  import lms_pkg::*;
  localparam logic [63:0] PAT = 64'h9e37_1c5a_f00d_4b21;
  localparam logic [7:0] FTAB [8] = '{8'ha1, 8'h80, 8'h60, 8'h41,
    8'he0, 8'h17, 8'h31, 8'h08};
  logic clk_i = 1'h0, nrst_i = 1'h0;
  lms_mode_t mode_i = LMS_MODE_RAM;
  lms_org_t org_i = LMS_ORG_16X4;
  logic [3:0] addr_i = 4'h0, read_addr_i = 4'h0, data_i = 4'h0;
  logic [3:0] ff_en_i = 4'hf, ff_tap_sel_i = 4'h0;
  logic upper_address_five_i = 1'h0, upper_address_six_i = 1'h0;
  logic write_en_i = 1'h0, shift_en_i = 1'h0, chain_in_i;
  logic local_force_input_i = 1'h0, opposite_force_input_i = 1'h0;
  logic force_to_one_i = 1'h0, force_async_i = 1'h0;
  logic start_one_i = 1'h0, start_sel_i = 1'h0;
  logic global_init_i = 1'h0, global_init_invert_i = 1'h0;
  logic [3:0] primary_read_out_o, ff_q_o, chain_tap_out_o;
  logic secondary_read_out_o, chain_out_o;
  int bad_count = 0, n_compared = 0;

  lms_slice i_dut (.clk_i, .nrst_i, .mode_i, .org_i, .addr_i,
    .read_addr_i, .upper_address_five_i, .upper_address_six_i, .data_i,
    .write_en_i, .shift_en_i, .chain_in_i, .ff_en_i, .ff_tap_sel_i,
    .local_force_input_i, .opposite_force_input_i, .force_to_one_i,
    .force_async_i, .start_one_i, .start_sel_i, .global_init_i,
    .global_init_invert_i, .primary_read_out_o, .secondary_read_out_o,
    .ff_q_o, .chain_tap_out_o, .chain_out_o);
  lms_feeder #(.PAT(PAT)) i_feed (.clk_i, .nrst_i, .step_i(shift_en_i),
    .bit_o(chain_in_i));

  // 10 MHz slice clock
  initial forever #50 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic check(input string nm, input logic [3:0] got,
    input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // leaves the strobe up so writes can run back to back
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    addr_i <= a;
    data_i <= d;
    write_en_i <= 1'h1;
    tick(1);
  endtask : wr

  // outputs are registered, so let the address settle for a few edges
  task automatic rdchk(input logic [3:0] a, input logic [3:0] e);
    addr_i <= a;
    tick(3);
    check("read", primary_read_out_o, e);
  endtask : rdchk

  function automatic logic [3:0] tap(input int a);
    return {PAT[15 - a], PAT[31 - a], PAT[47 - a], PAT[63 - a]};
  endfunction : tap

  task automatic sweep();
    for (int a = 0; a < 16; a++) begin
      rdchk(a[3:0], tap(a));
    end
    check("last", chain_tap_out_o, {PAT[0], PAT[16], PAT[32], PAT[48]});
    check("chain", {3'h0, chain_out_o}, {3'h0, PAT[0]});
  endtask : sweep

  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // the whole run needs well under a thousand cycles
  initial begin
    tick(3000);
    bad_count++;
    end_sim();
  end

  initial begin
    tick(10);
    nrst_i <= 1'h1;
    rdchk(4'h5, 4'h0);
    wr(4'h3, 4'ha);
    wr(4'h4, 4'h5);
    write_en_i <= 1'h0;
    rdchk(4'h3, 4'ha);
    rdchk(4'h4, 4'h5);
    check("stored", ff_q_o, 4'h5);
    ff_en_i <= 4'h0;
    rdchk(4'h3, 4'ha);
    check("held", ff_q_o, 4'h5);
    org_i <= LMS_ORG_DUAL;
    wr(4'h7, 4'h1);
    write_en_i <= 1'h0;
    addr_i <= 4'h2;
    read_addr_i <= 4'h7;
    tick(3);
    check("second", {3'h0, secondary_read_out_o}, 4'h1);
    read_addr_i <= 4'h2;
    tick(3);
    check("second", {3'h0, secondary_read_out_o}, 4'h0);
    org_i <= LMS_ORG_64X1;
    upper_address_five_i <= 1'h1;
    upper_address_six_i <= 1'h1;
    wr(4'h9, 4'h1);
    write_en_i <= 1'h0;
    rdchk(4'h9, 4'h1);
    upper_address_six_i <= 1'h0;
    upper_address_five_i <= 1'h0;
    rdchk(4'h9, 4'h0);
    org_i <= LMS_ORG_32X2;
    upper_address_five_i <= 1'h1;
    wr(4'h2, 4'h2);
    write_en_i <= 1'h0;
    ff_tap_sel_i <= 4'h8;
    ff_en_i <= 4'hf;
    rdchk(4'h2, 4'h2);
    check("tap ff", ff_q_o, 4'ha);
    ff_tap_sel_i <= 4'h0;
    // fill all four elements through the cascade, then hold
    mode_i <= LMS_MODE_SHIFT;
    shift_en_i <= 1'h1;
    tick(64);
    shift_en_i <= 1'h0;
    write_en_i <= 1'h1;
    data_i <= 4'hf;
    sweep();
    nrst_i <= 1'h0;
    tick(2);
    nrst_i <= 1'h1;
    sweep();
    write_en_i <= 1'h0;
    ff_en_i <= 4'hf;
    foreach (FTAB[i]) begin
      {local_force_input_i, opposite_force_input_i, force_to_one_i,
        global_init_i, global_init_invert_i, start_sel_i,
        start_one_i} <= FTAB[i][7:1];
      force_async_i <= i[0];
      tick(3);
      check("ff", ff_q_o, {4{FTAB[i][0]}});
    end
    end_sim();
  end
endmodule : lms_slice_bench
`default_nettype wire
